// >>> inc/ggc_pkg.sv
// Purpose: constants and types of the gauge control subcommand block
// Assumes: 40 MHz mclk; host link is a two-wire serial bus sampled by mclk
// Notes: subcommand words arrive through link pointer bytes 0x00 and 0x01
// How it works
// - Host writes low then high byte at control port; high byte starts decode.
// - Locked state honours status, identity, chemistry, hibernate, and stored-value reads of 0x0004, 0x0009, 0x000a.
// - Subcommand 0x0000 loads gauge state word into control port result.
// - State word high byte: full lock, lock, sum valid, coulomb cal, board cal, one.
// - State word low byte: hibernate, sleep, power model, resistance off, fit, learn.
// - Hibernate request bit asks for hibernate from sleep; resets to zero.
// - Power model bit is one for constant power; zero means constant current.
// - Subcommands 1, 2, 3 return part kind, firmware and silicon revision.
// - Unlocked 0x0004 captures flash sum, returns it, sets sum valid.
// - Locked 0x0004 computes nothing but returns stored sum.
// - Subcommand 0x0005 returns full resets low, partial resets high.
// - Subcommand 0x0007 returns the previously written subcommand word.
// - Subcommand 0x0008 returns the chemistry code.
// - Unlocked 0x0009 measures offset shorted then open; difference is board offset.
// - After about 32 s return board offset, store it, set board cal flag.
// - Locked 0x0009 only returns stored board offset.
// - Unlocked 0x000a measures shorted offset; locked returns stored value.
// - Shorted offset measurement returns its value after about 16 s.
// - Subcommand 0x000b writes coulomb offset to flash.
// - 0x0011 sets, 0x0012 clears hibernate request, in both states.
// - 0x0020 enters locked state, accepted only while unlocked.
// - Unlocked 0x0021, 0x0022, 0x0040, 0x0041 start algo, code sum, cal, reset.
// - Leaving hibernate clears the hibernate request bit.
// - Control port stays readable and writable in both access states.
package ggc_pkg;
  localparam logic [6:0] DEV_ADDR = 7'h2a; // Arbitrary link address
  localparam logic [7:0] PTR_CTRL_LO = 8'h00;
  localparam logic [7:0] PTR_CTRL_HI = 8'h01;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Identity values below are arbitrary
  localparam logic [15:0] PART_KIND = 16'h0a5c;
  localparam logic [15:0] FW_REV = 16'h0102;
  localparam logic [15:0] SILICON_REV = 16'h0003;
  localparam logic [15:0] CHEM_CODE = 16'h0100;
  localparam logic LOCK_AT_RESET = 1'b0;
  localparam logic [15:0] SC_STATUS = 16'h0000, SC_PART = 16'h0001, SC_FW = 16'h0002;
  localparam logic [15:0] SC_HW = 16'h0003, SC_FLASH_SUM = 16'h0004, SC_RESET_CNT = 16'h0005;
  localparam logic [15:0] SC_LAST = 16'h0007, SC_CHEM = 16'h0008, SC_BOARD = 16'h0009;
  localparam logic [15:0] SC_CC_MEAS = 16'h000a, SC_CC_STORE = 16'h000b;
  localparam logic [15:0] SC_HIB_SET = 16'h0011, SC_HIB_CLR = 16'h0012, SC_LOCK = 16'h0020;
  localparam logic [15:0] SC_ALGO = 16'h0021, SC_CODE_SUM = 16'h0022;
  localparam logic [15:0] SC_CAL_MODE = 16'h0040, SC_FULL_RST = 16'h0041;
  localparam int SB_FULL_LOCK = 14, SB_LOCK = 13, SB_SUM_OK = 12, SB_CC_CAL = 11;
  localparam int SB_BRD_CAL = 10, SB_ONE = 9, SB_HIB = 6, SB_SLEEP = 4;
  localparam int SB_PWR_MODEL = 3, SB_RES_OFF = 2, SB_VFIT = 1, SB_LEARN = 0;
  localparam logic [1:0] FL_BOARD = 2'h1, FL_CC = 2'h2;
  localparam int TMR_W = 32;
  localparam longint unsigned MCLK_HZ = 40_000_000;
  localparam longint unsigned BOARD_CAL_S = 32;
  localparam longint unsigned CC_CAL_S = 16;
  localparam longint unsigned BOARD_CAL_CYC = BOARD_CAL_S * MCLK_HZ;
  localparam longint unsigned CC_CAL_CYC = CC_CAL_S * MCLK_HZ;
  typedef enum logic [2:0] {I_IDLE = 3'h0, I_ADDR = 3'h1, I_AACK = 3'h3, I_RX = 3'h2,
    I_RACK = 3'h6, I_TX = 3'h7, I_TACK = 3'h5} ggc_link_st_t;
  typedef enum logic [1:0] {C_IDLE = 2'h0, C_SHORT = 2'h1, C_OPEN = 2'h3,
    C_CC = 2'h2} ggc_cal_st_t;
endpackage

// >>> inc/ggc_tmr_if.sv
// Purpose: start and done handshake between decoder and calibration timer
// Assumes: both ends on mclk
// Notes: start is a one-cycle pulse, load is sampled with it
`timescale 1ns/1ps
interface ggc_tmr_if;
  logic start;
  logic [31:0] load;
  logic done;
  modport ctl (output start, output load, input done);
  modport tmr (input start, input load, output done);
endinterface

// >>> verilog/ggc_sync2.sv
// Purpose: two-flop synchroniser for one link pin
// Assumes: input is asynchronous to mclk
// Notes: only the second flop is visible outside
`timescale 1ns/1ps
module ggc_sync2 #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  typedef struct packed {
    logic ff1;
    logic ff2;
  } ggc_sync_t;
  ggc_sync_t s, next_s;
  always_comb
  begin
    next_s.ff1 = d;
    next_s.ff2 = s.ff1;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s <= {RST_VAL, RST_VAL};
    else
      s <= next_s;
  end
  assign q = s.ff2;
endmodule

// >>> verilog/ggc_cal_timer.sv
// Purpose: down counter timing offset measurement phases
// Assumes: load is at least one cycle
// Notes: done pulses load plus one cycles after start
`timescale 1ns/1ps
module ggc_cal_timer import ggc_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  ggc_tmr_if.tmr tif
);
  typedef struct packed {
    logic [TMR_W-1:0] cnt;
    logic done;
  } ggc_tmr_t;
  ggc_tmr_t s, next_s;
  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    if (tif.start)
      next_s.cnt = tif.load;
    else if (s.cnt != '0)
    begin
      next_s.cnt = s.cnt - 32'h1;
      next_s.done = (s.cnt == 32'h1);
    end
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      s <= '0;
    else
      s <= next_s;
  end
  assign tif.done = s.done;
endmodule

// >>> verilog/ggc_control.sv
// Purpose: control port subcommand decoder with two-wire host link slave
// Assumes: status and measurement inputs come from logic on mclk
// Notes: only link pointers 0x00 and 0x01 are mapped; others read zero
`timescale 1ns/1ps
module ggc_control import ggc_pkg::*; #(
  parameter logic [TMR_W-1:0] BOARD_CAL_CYCLES = TMR_W'(BOARD_CAL_CYC),
  parameter logic [TMR_W-1:0] CC_CAL_CYCLES = TMR_W'(CC_CAL_CYC)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic sleep_mode,
  input wire logic power_model_flag,
  input wire logic resistance_update_off,
  input wire logic voltage_unfit,
  input wire logic hibernate_exit,
  input wire logic [7:0] full_reset_count,
  input wire logic [7:0] partial_reset_count,
  input wire logic [15:0] flash_sum_in,
  input wire logic [15:0] code_sum_in,
  input wire logic [15:0] cc_meas_in,
  output logic sense_short,
  output logic cal_mode,
  output logic algo_start,
  output logic full_reset,
  output logic hibernate_req,
  output logic locked,
  output logic flash_wr,
  output logic [1:0] flash_wr_sel,
  output logic [15:0] flash_wr_data
);
  localparam logic [TMR_W-1:0] BRD_HALF = BOARD_CAL_CYCLES >> 1;

  typedef struct packed {
    ggc_link_st_t st;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rw;
    logic first;
    logic nack;
    logic [7:0] ptr;
    logic [7:0] cmd_lo;
    logic scl_d;
    logic sda_d;
    logic sda_oe;
    logic [15:0] result;
    logic [15:0] last_cmd;
    logic [15:0] df_sum;
    logic [15:0] boff;
    logic [15:0] cc_off;
    logic [15:0] samp;
    logic lock;
    logic full_lock;
    logic sum_ok;
    logic board_cal_active;
    logic hib;
    logic learn;
    logic vfit;
    logic cal_mode;
    ggc_cal_st_t cal;
    logic sense_short;
    logic algo_start;
    logic full_reset;
    logic flash_wr;
    logic [1:0] flash_sel;
    logic [15:0] flash_data;
    logic tstart;
    logic [TMR_W-1:0] tload;
  } ggc_state_t;

  ggc_state_t s, next_s;
  ggc_tmr_if tif();
  logic scl_s, sda_s;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic cmd_go, cmd_take;
  logic [15:0] cmd_word, st_word, diff;
  logic [7:0] txb;

  ggc_sync2 #(.RST_VAL(1'b1)) u_sync_scl (
    .mclk(mclk),
    .rst(rst),
    .d(scl),
    .q(scl_s)
  );
  ggc_sync2 #(.RST_VAL(1'b1)) u_sync_sda (
    .mclk(mclk),
    .rst(rst),
    .d(sda_in),
    .q(sda_s)
  );
  ggc_cal_timer u_timer (
    .mclk(mclk),
    .rst(rst),
    .tif(tif)
  );
  assign tif.start = s.tstart;
  assign tif.load = s.tload;

  function automatic logic [7:0] rd_byte(input logic [7:0] p, input logic [15:0] r);
    // Control port is readable in either access state
    if (p == PTR_CTRL_LO)
      return r[7:0];
    else if (p == PTR_CTRL_HI)
      return r[15:8];
    else
      return RD_UNMAPPED;
  endfunction

  always_comb
  begin
    st_word = '0;
    st_word[SB_FULL_LOCK] = s.full_lock;
    st_word[SB_LOCK] = s.lock;
    st_word[SB_SUM_OK] = s.sum_ok;
    st_word[SB_CC_CAL] = (s.cal == C_CC);
    st_word[SB_BRD_CAL] = s.board_cal_active;
    st_word[SB_ONE] = 1'b1;
    st_word[SB_HIB] = s.hib;
    st_word[SB_SLEEP] = sleep_mode;
    st_word[SB_PWR_MODEL] = power_model_flag;
    st_word[SB_RES_OFF] = resistance_update_off;
    st_word[SB_VFIT] = s.vfit;
    st_word[SB_LEARN] = s.learn;
  end

  assign scl_rise = scl_s & ~s.scl_d;
  assign scl_fall = ~scl_s & s.scl_d;
  assign start_c = scl_s & s.scl_d & s.sda_d & ~sda_s;
  assign stop_c = scl_s & s.scl_d & ~s.sda_d & sda_s;
  assign diff = cc_meas_in - s.samp;

  always_comb
  begin
    next_s = s;
    cmd_go = 1'b0;
    cmd_word = '0;
    txb = '0;
    next_s.tstart = 1'b0;
    next_s.algo_start = 1'b0;
    next_s.full_reset = 1'b0;
    next_s.flash_wr = 1'b0;
    next_s.scl_d = scl_s;
    next_s.sda_d = sda_s;
    // Link slave; no clock stretching, so the host sets the pace
    if (start_c)
    begin
      next_s.st = I_ADDR;
      next_s.bitcnt = '0;
      next_s.first = 1'b1;
      next_s.sda_oe = 1'b0;
    end
    else if (stop_c)
    begin
      next_s.st = I_IDLE;
      next_s.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      if (s.st == I_ADDR || s.st == I_RX)
      begin
        next_s.shreg = {s.shreg[6:0], sda_s};
        next_s.bitcnt = s.bitcnt + 4'h1;
      end
      if (s.st == I_TACK)
        next_s.nack = sda_s;
    end
    else if (scl_fall)
    begin
      unique case (s.st)
        I_IDLE:
          next_s.st = I_IDLE;
        I_ADDR:
          if (s.bitcnt == BYTE_BITS)
          begin
            if (s.shreg[7:1] == DEV_ADDR)
            begin
              next_s.st = I_AACK;
              next_s.sda_oe = 1'b1;
              next_s.rw = s.shreg[0];
            end
            else
              next_s.st = I_IDLE;
          end
        I_AACK:
        begin
          if (s.rw)
          begin
            txb = rd_byte(s.ptr, s.result);
            next_s.st = I_TX;
            next_s.shreg = txb;
            next_s.sda_oe = ~txb[7];
            next_s.bitcnt = 4'h1;
          end
          else
          begin
            next_s.st = I_RX;
            next_s.sda_oe = 1'b0;
            next_s.bitcnt = '0;
          end
        end
        I_RX:
          if (s.bitcnt == BYTE_BITS)
          begin
            next_s.st = I_RACK;
            next_s.sda_oe = 1'b1;
            if (s.first)
            begin
              next_s.ptr = s.shreg;
              next_s.first = 1'b0;
            end
            else
            begin
              next_s.ptr = s.ptr + 8'h1;
              if (s.ptr == PTR_CTRL_LO)
                next_s.cmd_lo = s.shreg;
              if (s.ptr == PTR_CTRL_HI)
              begin
                cmd_go = 1'b1;
                cmd_word = {s.shreg, s.cmd_lo};
              end
            end
          end
        I_RACK:
        begin
          next_s.st = I_RX;
          next_s.sda_oe = 1'b0;
          next_s.bitcnt = '0;
        end
        I_TX:
          if (s.bitcnt == BYTE_BITS)
          begin
            next_s.st = I_TACK;
            next_s.sda_oe = 1'b0;
          end
          else
          begin
            next_s.sda_oe = ~s.shreg[6];
            next_s.shreg = {s.shreg[6:0], 1'b0};
            next_s.bitcnt = s.bitcnt + 4'h1;
          end
        I_TACK:
          if (!s.nack)
          begin
            next_s.ptr = s.ptr + 8'h1;
            txb = rd_byte(next_s.ptr, s.result);
            next_s.st = I_TX;
            next_s.shreg = txb;
            next_s.sda_oe = ~txb[7];
            next_s.bitcnt = 4'h1;
          end
          else
            next_s.st = I_IDLE;
        default:
          next_s.st = I_IDLE;
      endcase
    end

    // Offset measurement phases; board offset uses two equal halves
    if (tif.done)
    begin
      unique case (s.cal)
        C_IDLE:
          next_s.cal = C_IDLE;
        C_SHORT:
        begin
          next_s.samp = cc_meas_in;
          next_s.cal = C_OPEN;
          next_s.sense_short = 1'b0;
          next_s.tstart = 1'b1;
          next_s.tload = BRD_HALF;
        end
        C_OPEN:
        begin
          next_s.boff = diff;
          next_s.result = diff;
          next_s.board_cal_active = 1'b1;
          next_s.flash_wr = 1'b1;
          next_s.flash_sel = FL_BOARD;
          next_s.flash_data = diff;
          next_s.cal = C_IDLE;
        end
        C_CC:
        begin
          next_s.cc_off = cc_meas_in;
          next_s.result = cc_meas_in;
          next_s.sense_short = 1'b0;
          next_s.cal = C_IDLE;
        end
      endcase
    end

    // A running measurement owns the result word, so words sent meanwhile are dropped
    cmd_take = cmd_go && (s.cal == C_IDLE);
    if (hibernate_exit)
      next_s.hib = 1'b0;
    if (voltage_unfit)
      next_s.vfit = 1'b0;
    if (cmd_take)
    begin
      if (cmd_word != SC_LAST)
        next_s.last_cmd = cmd_word;
      unique case (cmd_word)
        SC_STATUS:
          next_s.result = st_word;
        SC_PART:
          next_s.result = PART_KIND;
        SC_FW:
          next_s.result = FW_REV;
        SC_HW:
          next_s.result = SILICON_REV;
        SC_CHEM:
          next_s.result = CHEM_CODE;
        SC_FLASH_SUM:
          if (!s.lock)
          begin
            next_s.df_sum = flash_sum_in;
            next_s.sum_ok = 1'b1;
            next_s.result = flash_sum_in;
          end
          else
            next_s.result = s.df_sum;
        SC_RESET_CNT:
          if (!s.lock)
            next_s.result = {partial_reset_count, full_reset_count};
        SC_LAST:
          if (!s.lock)
            next_s.result = s.last_cmd;
        SC_BOARD:
          if (!s.lock)
          begin
            next_s.cal = C_SHORT;
            next_s.sense_short = 1'b1;
            next_s.tstart = 1'b1;
            next_s.tload = BRD_HALF;
          end
          else
            next_s.result = s.boff;
        SC_CC_MEAS:
          if (!s.lock)
          begin
            next_s.cal = C_CC;
            next_s.sense_short = 1'b1;
            next_s.tstart = 1'b1;
            next_s.tload = CC_CAL_CYCLES;
          end
          else
            next_s.result = s.cc_off;
        SC_CC_STORE:
          if (!s.lock)
          begin
            next_s.flash_wr = 1'b1;
            next_s.flash_sel = FL_CC;
            next_s.flash_data = s.cc_off;
          end
        SC_HIB_SET:
          next_s.hib = 1'b1;
        SC_HIB_CLR:
          next_s.hib = 1'b0;
        SC_LOCK:
          if (!s.lock)
          begin
            next_s.lock = 1'b1;
            next_s.full_lock = 1'b1;
          end
        SC_ALGO:
          if (!s.lock)
          begin
            next_s.learn = 1'b1;
            next_s.vfit = 1'b1;
            next_s.algo_start = 1'b1;
          end
        SC_CODE_SUM:
          if (!s.lock)
          begin
            next_s.result = code_sum_in;
            next_s.sum_ok = 1'b1;
          end
        SC_CAL_MODE:
          if (!s.lock)
            next_s.cal_mode = 1'b1;
        SC_FULL_RST:
          if (!s.lock)
            next_s.full_reset = 1'b1;
        default:
          next_s.result = s.result;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      s <= '0;
      s.scl_d <= 1'b1;
      s.sda_d <= 1'b1;
      s.lock <= LOCK_AT_RESET;
      s.full_lock <= LOCK_AT_RESET;
      s.hib <= 1'b0;
    end
    else
      s <= next_s;
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe = s.sda_oe;
  assign sense_short = s.sense_short;
  assign cal_mode = s.cal_mode;
  assign algo_start = s.algo_start;
  assign full_reset = s.full_reset;
  assign hibernate_req = s.hib;
  assign locked = s.lock;
  assign flash_wr = s.flash_wr;
  assign flash_wr_sel = s.flash_sel;
  assign flash_wr_data = s.flash_data;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence seq_cmd(logic [15:0] w);
    cmd_take && cmd_word == w;
  endsequence
  sequence seq_board_end;
    s.cal == C_OPEN && tif.done;
  endsequence

  a_ack_drive_low: assert property (s.st == I_AACK |-> s.sda_oe)
    else $error("address ack not driven");
  a_status_word: assert property (seq_cmd(SC_STATUS) |=> s.result[SB_ONE] &&
    s.result[SB_LOCK] == $past(s.lock) && s.result[SB_HIB] == $past(s.hib))
    else $error("state word not returned");
  a_ident_fw: assert property (seq_cmd(SC_FW) |=> s.result == FW_REV)
    else $error("firmware revision wrong");
  a_sum_capture: assert property (seq_cmd(SC_FLASH_SUM) ##0 !s.lock |=>
    s.sum_ok && s.result == $past(flash_sum_in))
    else $error("flash sum not captured");
  a_sum_locked: assert property (seq_cmd(SC_FLASH_SUM) ##0 s.lock |=>
    s.result == $past(s.df_sum) && $stable(s.df_sum))
    else $error("locked flash sum changed");
  a_reset_counts: assert property (seq_cmd(SC_RESET_CNT) ##0 !s.lock |=>
    s.result == {$past(partial_reset_count), $past(full_reset_count)})
    else $error("reset counts wrong");
  a_prev_cmd: assert property (seq_cmd(SC_LAST) ##0 !s.lock |=>
    s.result == $past(s.last_cmd))
    else $error("previous word wrong");
  a_board_start: assert property (seq_cmd(SC_BOARD) ##0 !s.lock |=>
    s.cal == C_SHORT && s.sense_short)
    else $error("board cal did not start");
  a_board_end: assert property (seq_board_end |=> s.board_cal_active &&
    s.flash_wr && s.result == $past(cc_meas_in) - $past(s.samp))
    else $error("board offset not returned");
  a_locked_board: assert property (seq_cmd(SC_BOARD) ##0 s.lock |=>
    s.cal == C_IDLE && s.result == $past(s.boff))
    else $error("locked board cal ran");
  a_cc_end: assert property (s.cal == C_CC && tif.done |=> s.cal == C_IDLE &&
    !s.sense_short && s.result == $past(cc_meas_in))
    else $error("coulomb offset not returned");
  a_hib_set: assert property (seq_cmd(SC_HIB_SET) |=> s.hib)
    else $error("hibernate not set");
  a_hib_exit: assert property (hibernate_exit && !cmd_take |=> !s.hib)
    else $error("hibernate not cleared on exit");
  a_lock_enter: assert property (seq_cmd(SC_LOCK) |=> s.lock && s.full_lock)
    else $error("lock not entered");
  // Full reset word is sent both before and after locking, so this one is reached
  a_locked_ignore: assert property (seq_cmd(SC_FULL_RST) ##0 s.lock |=>
    !s.full_reset && $stable(s.result) && $stable(s.last_cmd) == 1'b0 || !s.full_reset &&
    $stable(s.result))
    else $error("forbidden word acted on");
endmodule

// >>> verification/ggc_host_model.sv
// Purpose: two-wire bus master standing in for the host processor
// Assumes: steps on mclk falling edges, 8 mclk per bit
// Notes: sda is open drain, so the host only ever pulls it low
`timescale 1ns/1ps
module ggc_host_model import ggc_pkg::*; (
  input wire logic mclk,
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  logic ack;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    ack = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // Data only moves while scl is low, so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda;
    tick(2);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start;
    sda_low = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b1;
    tick(4);
    scl = 1'b0;
    tick(2);
  endtask
  // Clock left high after stop: it stands still between frames
  task automatic stop;
    sda_low = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_low = 1'b0;
    tick(4);
  endtask
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(d[i], s);
      q[i] = s;
    end
    bit_io(last, s);
    ack = ~s;
  endtask
  task automatic wr_cmd(input logic [15:0] w);
    logic [7:0] q;
    start;
    xfer({DEV_ADDR, 1'b0}, 1'b1, q);
    xfer(PTR_CTRL_LO, 1'b1, q);
    xfer(w[7:0], 1'b1, q);
    xfer(w[15:8], 1'b1, q);
    stop;
  endtask
  task automatic rd(input logic [7:0] ptr, output logic [15:0] r);
    logic [7:0] q;
    start;
    xfer({DEV_ADDR, 1'b0}, 1'b1, q);
    xfer(ptr, 1'b1, q);
    start;
    xfer({DEV_ADDR, 1'b1}, 1'b1, q);
    xfer(8'hff, 1'b0, r[7:0]);
    xfer(8'hff, 1'b1, r[15:8]);
    stop;
  endtask
endmodule

// >>> verification/tb_ggc_control.sv
// Purpose: self-checking bench for the control subcommand decoder
// Assumes: host model speaks the two-wire link, short calibration counts
// Notes: pulse outputs are counted every rising mclk edge
`timescale 1ns/1ps
module tb_ggc_control import ggc_pkg::*;;
  logic mclk = 1'b0, rst = 1'b1, scl, sda_low, sda_out, sda_oe, sda;
  logic sleep_mode = 1'b1, power_model_flag = 1'b0, resistance_update_off = 1'b1;
  logic voltage_unfit = 1'b0, hibernate_exit = 1'b0;
  logic [7:0] full_reset_count = 8'h12, partial_reset_count = 8'h34;
  logic [15:0] flash_sum_in = 16'hbeef, code_sum_in = 16'h5aa5, cc_meas_in = 16'h0033;
  logic sense_short, cal_mode, algo_start, full_reset, hibernate_req, locked, flash_wr;
  logic [1:0] flash_wr_sel;
  logic [15:0] flash_wr_data, r;
  logic [15:0] ids [4] = '{SC_PART, SC_FW, SC_HW, SC_CHEM};
  logic [15:0] exps [4] = '{PART_KIND, FW_REV, SILICON_REV, CHEM_CODE};
  // Host also sends the unmapped word 0x0030, which falls to the default branch
  logic [15:0] acts [4] = '{SC_ALGO, SC_CAL_MODE, SC_FULL_RST, 16'h0030};
  int n_mismatch = 0, checks_done = 0, n_algo = 0, n_frst = 0, n_fwr = 0, cyc = 0;
  assign sda = ~(sda_low | (sda_oe & ~sda_out));
  always #12.5 mclk = ~mclk;
  ggc_control #(.BOARD_CAL_CYCLES(32'd64), .CC_CAL_CYCLES(32'd32)) ggc_control_inst (
    .mclk, .rst, .scl, .sda_in(sda), .sda_out, .sda_oe, .sleep_mode, .power_model_flag,
    .resistance_update_off, .voltage_unfit, .hibernate_exit, .full_reset_count,
    .partial_reset_count, .flash_sum_in, .code_sum_in, .cc_meas_in, .sense_short,
    .cal_mode, .algo_start, .full_reset, .hibernate_req, .locked, .flash_wr,
    .flash_wr_sel, .flash_wr_data);
  ggc_host_model ggc_host_model_inst (.mclk, .sda, .scl, .sda_low);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] w);
    ggc_host_model_inst.wr_cmd(w);
  endtask
  task automatic cmd_rd(input logic [15:0] w, input logic [15:0] exp);
    wr(w);
    ggc_host_model_inst.rd(PTR_CTRL_LO, r);
    chk(r, exp);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Ceiling well above the roughly 16.5k cycles the sequence needs
  always @(posedge mclk)
  begin
    cyc++;
    n_algo += algo_start;
    n_frst += full_reset;
    n_fwr += flash_wr;
    if (cyc == 60000)
    begin
      n_mismatch++;
      results;
    end
  end
  initial
  begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    cmd_rd(SC_STATUS, 16'h0214);
    foreach (ids[i]) cmd_rd(ids[i], exps[i]);
    cmd_rd(SC_RESET_CNT, 16'h3412);
    cmd_rd(SC_LAST, SC_RESET_CNT);
    cmd_rd(SC_FLASH_SUM, 16'hbeef);
    cmd_rd(SC_CODE_SUM, 16'h5aa5);
    wr(SC_HIB_SET);
    chk(hibernate_req, 1'b1);
    hibernate_exit = 1'b1;
    @(negedge mclk);
    hibernate_exit = 1'b0;
    chk(hibernate_req, 1'b0);
    wr(SC_HIB_SET);
    wr(SC_HIB_CLR);
    chk(hibernate_req, 1'b0);
    chk(ggc_host_model_inst.ack, 1'b1);
    foreach (acts[i]) wr(acts[i]);
    chk(n_algo, 1);
    chk(n_frst, 1);
    chk(cal_mode, 1'b1);
    ggc_host_model_inst.rd(PTR_CTRL_LO, r);
    chk(r, 16'h5aa5);
    wr(SC_CC_MEAS);
    chk(sense_short, 1'b1);
    repeat (40) @(negedge mclk);
    chk(sense_short, 1'b0);
    ggc_host_model_inst.rd(PTR_CTRL_LO, r);
    chk(r, 16'h0033);
    wr(SC_CC_STORE);
    chk(n_fwr, 1);
    chk(flash_wr_sel, FL_CC);
    chk(flash_wr_data, 16'h0033);
    cc_meas_in = 16'h0010;
    wr(SC_BOARD);
    chk(sense_short, 1'b1);
    for (int i = 0; i < 100 && sense_short; i++) @(negedge mclk);
    cc_meas_in = 16'h0050;
    repeat (40) @(negedge mclk);
    ggc_host_model_inst.rd(PTR_CTRL_LO, r);
    chk(r, 16'h0040);
    chk(n_fwr, 2);
    chk(flash_wr_sel, FL_BOARD);
    chk(flash_wr_data, 16'h0040);
    wr(SC_LOCK);
    chk(locked, 1'b1);
    flash_sum_in = 16'h1111;
    cc_meas_in = 16'h7777;
    cmd_rd(SC_FLASH_SUM, 16'hbeef);
    cmd_rd(SC_BOARD, 16'h0040);
    cmd_rd(SC_CC_MEAS, 16'h0033);
    cmd_rd(SC_RESET_CNT, 16'h0033);
    foreach (acts[i]) wr(acts[i]);
    chk(n_algo, 1);
    chk(n_frst, 1);
    chk(n_fwr, 2);
    wr(SC_HIB_SET);
    chk(hibernate_req, 1'b1);
    sleep_mode = 1'b0;
    power_model_flag = 1'b1;
    resistance_update_off = 1'b0;
    voltage_unfit = 1'b1;
    @(negedge mclk);
    voltage_unfit = 1'b0;
    cmd_rd(SC_STATUS, 16'h7649);
    ggc_host_model_inst.rd(8'h02, r);
    chk(r, 16'h0000);
    results;
  end
endmodule
